// ---- inc/ptec_pkg.sv ----
package ptec_pkg;
  localparam int PTEC_CHANNELS = 8;
  localparam int PTEC_PINS = 32;
  localparam logic [11:0] PTEC_OFS_TASK_OUT = 12'h000;
  localparam logic [11:0] PTEC_OFS_TASK_SET = 12'h030;
  localparam logic [11:0] PTEC_OFS_TASK_CLR = 12'h060;
  localparam logic [11:0] PTEC_OFS_EVENT_IN = 12'h100;
  localparam logic [11:0] PTEC_OFS_INT_ENABLE = 12'h304;
  localparam logic [11:0] PTEC_OFS_INT_DISABLE = 12'h308;
  localparam logic [11:0] PTEC_OFS_CONFIG = 12'h510;
  localparam logic [11:0] PTEC_OFS_GPIO_OUT = 12'h600;
  localparam logic [11:0] PTEC_OFS_GPIO_OE = 12'h604;
  localparam logic [11:0] PTEC_OFS_PIN_IN = 12'h608;
  localparam int PTEC_MODE_LSB = 0;
  localparam int PTEC_PSEL_LSB = 8;
  localparam int PTEC_POL_LSB = 16;
  localparam int PTEC_INIT_BIT = 20;
  localparam logic [31:0] PTEC_CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] PTEC_CONFIG_MASK = 32'h0013_1F03;
  localparam logic [1:0] PTEC_MODE_DISABLED = 2'h0;
  localparam logic [1:0] PTEC_MODE_EVENT = 2'h1;
  localparam logic [1:0] PTEC_MODE_TASK = 2'h3;
  localparam logic [1:0] PTEC_POL_NONE = 2'h0;
  localparam logic [1:0] PTEC_POL_RISE = 2'h1;
  localparam logic [1:0] PTEC_POL_FALL = 2'h2;
  localparam logic [1:0] PTEC_POL_TOGGLE = 2'h3;
  typedef struct packed {
    logic [1:0] mode;
    logic [4:0] pin;
    logic [1:0] action;
    logic init;
  } ptec_cfg_s;
endpackage : ptec_pkg

// ---- inc/ptec_chan_if.sv ----
`timescale 1ns/1ps
interface ptec_chan_if;
  import ptec_pkg::*;
  ptec_cfg_s cfg;
  logic cfg_wr;
  logic task_out;
  logic task_set;
  logic task_clr;
  logic pin_level;
  logic event_pulse;
  logic drive_en;
  logic drive_val;
  modport ctrl (output cfg, output cfg_wr, output task_out, output task_set, output task_clr, output pin_level,
    input event_pulse, input drive_en, input drive_val);
  modport chan (input cfg, input cfg_wr, input task_out, input task_set, input task_clr, input pin_level,
    output event_pulse, output drive_en, output drive_val);
endinterface : ptec_chan_if

// ---- hw/ptec_channel.sv ----
`timescale 1ns/1ps
module ptec_channel
  import ptec_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  ptec_chan_if.chan ch
);
  logic prev_level;
  logic prev_valid;
  logic out_level;
  logic rise;
  logic fall;
  logic load_init;

  assign rise = prev_valid && !prev_level && ch.pin_level;
  assign fall = prev_valid && prev_level && !ch.pin_level;

  // The stored word lands on the write edge, so the initial level is loaded one edge later
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      load_init <= 1'b0;
    else
      load_init <= ch.cfg_wr;
  end

  // Edge history restarts on reconfiguration so a pin switch is not seen as an edge
  always_ff @(posedge clk_i)
  begin
    if (srst_i || ch.cfg_wr || ch.cfg.mode != PTEC_MODE_EVENT)
    begin
      prev_valid <= 1'b0;
      prev_level <= 1'b0;
    end
    else
    begin
      prev_valid <= 1'b1;
      prev_level <= ch.pin_level;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ch.event_pulse <= 1'b0;
    else if (ch.cfg.mode == PTEC_MODE_EVENT)
    begin
      case (ch.cfg.action)
        PTEC_POL_RISE: ch.event_pulse <= rise;
        PTEC_POL_FALL: ch.event_pulse <= fall;
        PTEC_POL_TOGGLE: ch.event_pulse <= rise || fall;
        default: ch.event_pulse <= 1'b0;
      endcase
    end
    else
      ch.event_pulse <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      out_level <= 1'b0;
    else if (load_init)
      out_level <= ch.cfg.init;
    else if (ch.task_set)
      out_level <= 1'b1;
    else if (ch.task_clr)
      out_level <= 1'b0;
    else if (ch.task_out)
    begin
      case (ch.cfg.action)
        PTEC_POL_RISE: out_level <= 1'b1;
        PTEC_POL_FALL: out_level <= 1'b0;
        PTEC_POL_TOGGLE: out_level <= !out_level;
        default: out_level <= out_level;
      endcase
    end
  end

  assign ch.drive_en = (ch.cfg.mode == PTEC_MODE_TASK);
  assign ch.drive_val = load_init ? ch.cfg.init : out_level;
endmodule : ptec_channel

// ---- hw/ptec_unit.sv ----
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Mode 0: channel neither drives nor watches its pin.
// - Mode 1: channel watches its pin without driving it (GPIO output enable still applies); chosen edge raises the channel event.
// - Mode 3: channel drives its pin, controlled by set, clear, action tasks.
// - A task-mode channel blocks ordinary GPIO output writes to its pin.
// - Pin select 0..31 picks the one pin for all tasks and event.
// - Action task: 0 none, 1 high, 2 low, 3 invert.
// - Event trigger: 0 never, 1 rising, 2 falling, 3 any change.
// - On entering task mode pin starts at initial output level.
// - Drive-high task sets pin high, drive-low task sets it low.
// - Writing 1 to disable register clears enable; read shows enable.
module ptec_unit
  import ptec_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [ptec_pkg::PTEC_PINS-1:0] pin_i,
  output logic [ptec_pkg::PTEC_PINS-1:0] pin_o,
  output logic [ptec_pkg::PTEC_PINS-1:0] pin_oe_o,
  output logic irq_o
);
  localparam int NCH = PTEC_CHANNELS;

  logic [PTEC_PINS-1:0] pin_meta;
  logic [PTEC_PINS-1:0] pin_sync;
  ptec_cfg_s cfg [NCH];
  logic [NCH-1:0] cfg_wr;
  logic [NCH-1:0] task_out;
  logic [NCH-1:0] task_set;
  logic [NCH-1:0] task_clr;
  logic [NCH-1:0] event_pulse;
  logic [NCH-1:0] drive_en;
  logic [NCH-1:0] drive_val;
  logic [NCH-1:0] event_flag;
  logic [NCH-1:0] int_en;
  logic [PTEC_PINS-1:0] gpio_out;
  logic [PTEC_PINS-1:0] gpio_oe;
  logic access;
  logic wr;
  logic full_word;
  logic [2:0] idx;
  logic in_out;
  logic in_set;
  logic in_clr;
  logic in_evt;
  logic in_cfg;
  logic mapped;
  logic [31:0] next_rdata;
  logic aligned;
  logic rd_first;
  logic read_done;
  logic [31:0] read_data;
  logic wr_gpio_out;
  logic wr_gpio_oe;
  logic [PTEC_PINS-1:0] next_pin;
  logic [PTEC_PINS-1:0] next_oe;
  logic [PTEC_PINS-1:0] pin_drive;
  logic [PTEC_PINS-1:0] pin_enable;

  // Pins come from outside the clock domain
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pin_i;
      pin_sync <= pin_meta;
    end
  end

  assign access = psel_i && penable_i;
  // Misaligned writes answer with an error and change nothing
  assign aligned = (paddr_i[1:0] == 2'h0);
  assign wr = access && pwrite_i && aligned;
  // Partial-word writes to the config registers are ignored rather than merged
  assign full_word = (pstrb_i == 4'hF);
  assign idx = paddr_i[4:2];
  assign in_out = (paddr_i[11:5] == PTEC_OFS_TASK_OUT[11:5]) && !paddr_i[1];
  assign in_set = (paddr_i[11:2] >= PTEC_OFS_TASK_SET[11:2]) && (paddr_i[11:2] < PTEC_OFS_TASK_SET[11:2] + 10'h8);
  assign in_clr = (paddr_i[11:2] >= PTEC_OFS_TASK_CLR[11:2]) && (paddr_i[11:2] < PTEC_OFS_TASK_CLR[11:2] + 10'h8);
  assign in_evt = (paddr_i[11:5] == PTEC_OFS_EVENT_IN[11:5]);
  assign in_cfg = (paddr_i[11:2] >= PTEC_OFS_CONFIG[11:2]) && (paddr_i[11:2] < PTEC_OFS_CONFIG[11:2] + 10'h8);

  logic [2:0] sidx;
  logic [2:0] cidx;
  assign sidx = 3'(paddr_i[11:2] - PTEC_OFS_TASK_SET[11:2]);
  assign cidx = 3'(paddr_i[11:2] - PTEC_OFS_TASK_CLR[11:2]);
  logic [2:0] gidx;
  assign gidx = 3'(paddr_i[11:2] - PTEC_OFS_CONFIG[11:2]);

  assign mapped = in_out || in_set || in_clr || in_evt || in_cfg || paddr_i == PTEC_OFS_INT_ENABLE
    || paddr_i == PTEC_OFS_INT_DISABLE || paddr_i == PTEC_OFS_GPIO_OUT || paddr_i == PTEC_OFS_GPIO_OE
    || paddr_i == PTEC_OFS_PIN_IN;

  // Writes finish without wait; reads pay one wait state for registered read data
  assign rd_first = access && !pwrite_i && !read_done;
  assign pready_o = !rd_first;
  assign pslverr_o = access && (!mapped || !aligned);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      read_done <= 1'b0;
    else
      read_done <= rd_first;
  end

  // Read data is zero outside the completing cycle of a read
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      read_data <= 32'h0000_0000;
    else if (rd_first)
      read_data <= next_rdata;
    else
      read_data <= 32'h0000_0000;
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_chan
      ptec_chan_if cif ();
      assign cif.cfg = cfg[g];
      assign cif.cfg_wr = cfg_wr[g];
      assign cif.task_out = task_out[g];
      assign cif.task_set = task_set[g];
      assign cif.task_clr = task_clr[g];
      assign cif.pin_level = pin_sync[cfg[g].pin];
      assign event_pulse[g] = cif.event_pulse;
      assign drive_en[g] = cif.drive_en;
      assign drive_val[g] = cif.drive_val;

      // Tasks are triggered by a write with bit 0 set; a write with bit 0 clear does nothing
      assign task_out[g] = wr && in_out && idx == 3'(g) && pwdata_i[0];
      assign task_set[g] = wr && in_set && sidx == 3'(g) && pwdata_i[0];
      assign task_clr[g] = wr && in_clr && cidx == 3'(g) && pwdata_i[0];
      assign cfg_wr[g] = wr && in_cfg && gidx == 3'(g) && full_word;

      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          cfg[g] <= '0;
        else if (cfg_wr[g])
        begin
          cfg[g].mode <= pwdata_i[PTEC_MODE_LSB +: 2];
          cfg[g].pin <= pwdata_i[PTEC_PSEL_LSB +: 5];
          cfg[g].action <= pwdata_i[PTEC_POL_LSB +: 2];
          cfg[g].init <= pwdata_i[PTEC_INIT_BIT];
        end
      end

      // Event set wins over a software clear in the same cycle
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          event_flag[g] <= 1'b0;
        else if (event_pulse[g])
          event_flag[g] <= 1'b1;
        else if (wr && in_evt && idx == 3'(g) && pwdata_i[0])
          event_flag[g] <= 1'b0;
      end

      ptec_channel u_chan (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ch(cif.chan)
      );
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      int_en <= '0;
    else if (wr && paddr_i == PTEC_OFS_INT_ENABLE)
      int_en <= int_en | pwdata_i[NCH-1:0];
    else if (wr && paddr_i == PTEC_OFS_INT_DISABLE)
      int_en <= int_en & ~pwdata_i[NCH-1:0];
  end

  assign irq_o = |(event_flag & int_en);

  assign wr_gpio_out = wr && paddr_i == PTEC_OFS_GPIO_OUT;
  assign wr_gpio_oe = wr && paddr_i == PTEC_OFS_GPIO_OE;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      gpio_out <= '0;
    else if (wr_gpio_out)
      gpio_out <= pwdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      gpio_oe <= '0;
    else if (wr_gpio_oe)
      gpio_oe <= pwdata_i;
  end

  // Pin mux; a higher channel wins when two claim the same pin
  generate
    for (g = 0; g < PTEC_PINS; g++)
    begin : g_pin
      logic [NCH-1:0] claim;
      logic own_val;
      always_comb
      begin
        claim = '0;
        own_val = 1'b0;
        for (int c = 0; c < NCH; c++)
        begin
          if (drive_en[c] && cfg[c].pin == 5'(g))
          begin
            claim[c] = 1'b1;
            own_val = drive_val[c];
          end
        end
      end
      assign next_pin[g] = (|claim) ? own_val : gpio_out[g];
      assign next_oe[g] = (|claim) || gpio_oe[g];
    end
  endgenerate

  // One flop stage keeps the pads free of decode glitches, at the cost of a cycle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pin_drive <= '0;
      pin_enable <= '0;
    end
    else
    begin
      pin_drive <= next_pin;
      pin_enable <= next_oe;
    end
  end

  assign pin_o = pin_drive;
  assign pin_oe_o = pin_enable;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (in_cfg)
      next_rdata = {11'h000, cfg[gidx].init, 2'h0, cfg[gidx].action, 3'h0, cfg[gidx].pin, 6'h00, cfg[gidx].mode};
    else if (in_evt)
      next_rdata = {31'h0000_0000, event_flag[idx]};
    else if (paddr_i == PTEC_OFS_INT_ENABLE || paddr_i == PTEC_OFS_INT_DISABLE)
      next_rdata = {24'h00_0000, int_en};
    else if (paddr_i == PTEC_OFS_GPIO_OUT)
      next_rdata = gpio_out;
    else if (paddr_i == PTEC_OFS_GPIO_OE)
      next_rdata = gpio_oe;
    else if (paddr_i == PTEC_OFS_PIN_IN)
      next_rdata = pin_sync;
  end

  assign prdata_o = read_data;
endmodule : ptec_unit

// ---- verification/ptec_unit_assertions.sv ----
`timescale 1ns/1ps
module ptec_unit_assertions
  import ptec_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [31:0] pin_i,
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [31:0] pin_q;
  logic [3:0] quiet;
  wire acc = psel_i && penable_i;
  wire wr = acc && pwrite_i;
  wire oe_wr = wr && (paddr_i == PTEC_OFS_GPIO_OE || (paddr_i >= PTEC_OFS_CONFIG && paddr_i <= 12'h52C));
  // Age of the last pin change, so an interrupt can be traced back to a real edge
  always_ff @(posedge clk_i)
  begin
    pin_q <= pin_i;
    if (srst_i || pin_i != pin_q)
    begin
      quiet <= srst_i ? 4'hF : 4'h0;
    end
    else if (quiet != 4'hF)
    begin
      quiet <= quiet + 4'h1;
    end
  end
  sequence s_disable_all;
    wr && paddr_i == PTEC_OFS_INT_DISABLE && pwdata_i[7:0] == 8'hFF;
  endsequence
  a_reset_quiet: assert property ($fell(srst_i) |-> pin_oe_o == 0 && pin_o == 0 && !irq_o)
    else $error("outputs busy after reset");
  a_oe_cause: assert property ($changed(pin_oe_o) |-> $past(oe_wr) || $past(oe_wr, 2))
    else $error("pin enable moved without a write");
  a_pin_cause: assert property ($changed(pin_o) |-> $past(wr) || $past(wr, 2))
    else $error("pin level moved without a write");
  a_disable_quiets: assert property (s_disable_all |=> !irq_o)
    else $error("irq stays after disable");
  a_irq_cause: assert property ($rose(irq_o) |-> quiet < 4'h6 || $past(wr && paddr_i == PTEC_OFS_INT_ENABLE))
    else $error("irq without pin edge");
  a_zero_wait: assert property (wr |-> pready_o)
    else $error("ready low in write access");
  a_read_wait: assert property (acc && !pwrite_i && !pready_o |=> pready_o)
    else $error("read wait longer than one cycle");
  a_unmapped_err: assert property (acc && paddr_i == 12'hFFC |-> pslverr_o)
    else $error("no error on unmapped");
  a_idle_data: assert property (!acc |-> prdata_o == 0)
    else $error("read data outside access");
endmodule : ptec_unit_assertions

bind ptec_unit ptec_unit_assertions i_chk (.clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pin_i, .pin_o, .pin_oe_o, .irq_o);

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  import ptec_pkg::*;
  logic clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o, er;
  logic [11:0] paddr_i, co;
  logic [31:0] pwdata_i, prdata_o, pin_i, pin_o, pin_oe_o, rd, gout, goe;
  logic [3:0] pstrb_i;
  int fail_count, num_checks, c, p, a, v, e;
  ptec_unit i_ptec_unit (.clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .pin_i, .pin_o, .pin_oe_o, .irq_o);
  initial
  begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Two idle edges after each transfer so task effects have landed before checks
  task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
    psel_i <= 1;
    paddr_i <= ad;
    pwrite_i <= w;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
    begin
      @(posedge clk_i);
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    repeat (2) @(posedge clk_i);
  endtask : apb
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  initial
  begin
    #50us;
    fail_count++;
    finish_test();
  end
  initial
  begin
    void'($urandom(42874));
    srst_i = 1;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    pstrb_i = 4'hF;
    pin_i = $urandom;
    repeat (6) @(posedge clk_i);
    srst_i <= 0;
    @(posedge clk_i);
    for (c = 0; c < 8; c++)
    begin
      apb(PTEC_OFS_CONFIG + 12'(4 * c), 0, 0);
      chk(rd, PTEC_CONFIG_RESET);
    end
    apb(12'hFFC, 0, 0);
    chk(32'(er), 1);
    apb(PTEC_OFS_GPIO_OE + 12'h2, 1, 32'hFFFF_FFFF);
    chk(32'(er), 1);
    chk(pin_oe_o, 0);
    c = $urandom_range(7);
    p = $urandom_range(31);
    co = 12'(4 * c);
    goe = $urandom;
    gout = $urandom & ~(1 << p);
    apb(PTEC_OFS_GPIO_OE, 1, goe);
    for (a = 0; a < 8; a++)
    begin
      v = a[2];
      apb(PTEC_OFS_CONFIG + co, 1, 32'h3 | p << 8 | (a & 3) << 16 | v << 20);
      chk(32'(pin_oe_o[p]), 1);
      chk(32'(pin_o[p]), v);
      apb(PTEC_OFS_TASK_OUT + co, 1, 1);
      v = (a & 3) == 0 ? v : (a & 3) == 3 ? !v : (a & 3) == 1;
      chk(32'(pin_o[p]), v);
      apb(PTEC_OFS_TASK_CLR + co, 1, 1);
      chk(32'(pin_o[p]), 0);
      apb(PTEC_OFS_TASK_SET + co, 1, 1);
      chk(32'(pin_o[p]), 1);
    end
    pstrb_i <= 4'h7;
    apb(PTEC_OFS_CONFIG + co, 1, 0);
    pstrb_i <= 4'hF;
    chk(32'(pin_oe_o[p]), 1);
    apb(PTEC_OFS_GPIO_OUT, 1, gout);
    chk(32'(pin_o[p]), 1);
    apb(PTEC_OFS_CONFIG + co, 1, 0);
    chk(pin_o, gout);
    chk(pin_oe_o, goe);
    apb(PTEC_OFS_INT_ENABLE, 1, 32'(1 << c));
    for (a = 0; a < 5; a++)
    begin
      apb(PTEC_OFS_CONFIG + co, 1, (a < 4 ? 32'h1 | a << 16 : 32'h30000) | p << 8);
      for (v = 0; v < 2; v++)
      begin
        pin_i <= ($urandom & ~(1 << p)) | (~pin_i & (1 << p));
        repeat (6) @(posedge clk_i);
        e = a < 4 && (a == 3 || a == (pin_i[p] ? 1 : 2));
        chk(32'(irq_o), e);
        apb(PTEC_OFS_EVENT_IN + co, 0, 0);
        chk(rd & 1, e);
        apb(PTEC_OFS_EVENT_IN + co, 1, 1);
      end
    end
    apb(PTEC_OFS_CONFIG + co, 1, 32'h30001 | p << 8);
    pin_i[p] <= !pin_i[p];
    repeat (6) @(posedge clk_i);
    apb(PTEC_OFS_INT_DISABLE, 0, 0);
    chk(rd, 1 << c);
    chk(32'(irq_o), 1);
    apb(PTEC_OFS_INT_DISABLE, 1, 32'hFF);
    chk(32'(irq_o), 0);
    apb(PTEC_OFS_INT_DISABLE, 0, 0);
    chk(rd, 0);
    apb(PTEC_OFS_EVENT_IN + co, 0, 0);
    chk(rd, 1);
    apb(PTEC_OFS_PIN_IN, 0, 0);
    chk(rd, pin_i);
    finish_test();
  end
endmodule : tb
